// ### sxh_map.vh
// sxh_map.vh: offsets, field positions, reset values and codes for the exception unit
// assumes inclusion by bare name from the unit's design files
`ifndef SXH_MAP_VH
`define SXH_MAP_VH

// ------------------------------------------------------------
// register byte offsets on the ahb-lite slave
// ------------------------------------------------------------
`define SXH_OFF_MSTAT    12'h000
`define SXH_OFF_VER0     12'h004
`define SXH_OFF_VER1     12'h008
`define SXH_OFF_CAUSE    12'h00c
`define SXH_OFF_DBG      12'h010
`define SXH_OFF_SLOW     12'h014
`define SXH_OFF_SHIGH    12'h018
`define SXH_OFF_VECBASE  12'h01c
`define SXH_OFF_STATUS   12'h020

// ------------------------------------------------------------
// machine status fields (masks)
// ------------------------------------------------------------
`define SXH_MS_INTEN     32'h0000_0002
`define SXH_MS_BRKIP     32'h0000_0008
`define SXH_MS_ICON      32'h0000_0020
`define SXH_MS_DCON      32'h0000_0080
`define SXH_MS_EXCEN     32'h0000_0100
`define SXH_MS_EXCIP     32'h0000_0200
`define SXH_MS_WMASK     32'h0000_03aa
`define SXH_BIT_INTEN    1
`define SXH_BIT_BRKIP    3
`define SXH_BIT_EXCEN    8
`define SXH_BIT_EXCIP    9

// ------------------------------------------------------------
// configuration defaults
// ------------------------------------------------------------
`define SXH_MS_RESET     32'h0000_0000
`define SXH_VEC_BASE     32'h0000_0000
`define SXH_VEC_LOWMASK  32'h0000_007f
`define SXH_VER_NONE     2'h0
`define SXH_VER_BASIC    2'h1
`define SXH_VER_FULL     2'h2
`define SXH_VER_USR_LSB  24
`define SXH_USER_A       8'h00
`define SXH_USER_B       32'h0000_0000
`define SXH_IRQ_NONE     2'h0
`define SXH_IRQ_NORMAL   2'h1
`define SXH_IRQ_FAST     2'h2

// ------------------------------------------------------------
// exception cause codes
// ------------------------------------------------------------
`define SXH_EXC_NONE     4'h0
`define SXH_EXC_STREAM   4'h1
`define SXH_EXC_IBUS     4'h3
`define SXH_EXC_DBUS     4'h4
`define SXH_EXC_DIV      4'h5
`define SXH_EXC_FPU      4'h6
`define SXH_EXC_ILLEGAL  4'h2
`define SXH_EXC_STACK    4'h7

// ------------------------------------------------------------
// vector offsets from the base, debug stop delay
// ------------------------------------------------------------
`define SXH_VOFF_RESET   32'h0000_0000
`define SXH_VOFF_USER    32'h0000_0008
`define SXH_VOFF_IRQ     32'h0000_0010
`define SXH_VOFF_BRK     32'h0000_0018
`define SXH_VOFF_HWEXC   32'h0000_0020
`define SXH_STOP_DELAY   2'h2

`endif

// ### sxh_irq_sense.v
// sxh_irq_sense.v: interrupt input sense stage, edge or level
// assumes irq_in is synchronous to hclk
`timescale 1ns/1ps
`default_nettype none
`include "sxh_map.vh"

module sxh_irq_sense #(
	parameter       edge_sense_param    = 0,
	parameter       edge_polarity_param = 1,
	parameter [1:0] irq_use             = `SXH_IRQ_NORMAL
) (
	// clock and reset
	input  wire hclk,
	input  wire hresetn,
	// interrupt line and acknowledge
	input  wire irq_in,
	input  wire irq_ack,
	output wire irq_pending
);
	reg irq_prev_r;
	reg edge_seen_r;
	wire want_edge;
	wire irq_used;

	assign irq_used = (irq_use != `SXH_IRQ_NONE); // see RL12
	// polarity picks the one transition that counts
	assign want_edge = (edge_polarity_param != 0) ? (irq_in & ~irq_prev_r)
		: (~irq_in & irq_prev_r); // see RL11

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_prev_r  <= 1'b0;
			edge_seen_r <= 1'b0;
		end else begin
			irq_prev_r <= irq_in;
			// a new edge in the ack cycle is kept
			if (want_edge && irq_used)
				edge_seen_r <= 1'b1; // see RL9
			else if (irq_ack)
				edge_seen_r <= 1'b0;
		end
	end

	// level mode re-raises while the line stays high
	assign irq_pending = irq_used & ((edge_sense_param != 0) ? edge_seen_r : irq_in); // see RL10

endmodule
`default_nettype wire

// ### sxh_exc_unit.v
// sxh_exc_unit.v: exception, interrupt-sense, reset-state, vector and debug-halt unit
// assumes a core pipeline that reports events as one-cycle pulses and obeys the take outputs
`timescale 1ns/1ps
`default_nettype none
`include "sxh_map.vh"

// Functional notes
// RL1: fpu exceptions raise on underflow, overflow, divide by zero, illegal op, denormal.
// RL2: integer divide traps on zero divisor, and on signed divide overflow.
// RL3: instruction bus error response raises an exception when enabled.
// RL4: data bus load or store error response raises an exception when enabled.
// RL5: invalid major opcode raises illegal instruction exception when enabled.
// RL6: all-zero word traps if null option set, else runs as no-op.
// RL7: stream read errors trap only with stream exceptions and stream instructions on.
// RL8: stack pointer accesses checked against low and high limits; failure traps.
// RL9: edge mode detects only the transition picked by polarity.
// RL10: level mode pends while high and re-raises after handling if still high.
// RL11: with edge mode, polarity selects rising or falling edges.
// RL12: interrupt input ignored unless interrupts are configured, normal or fast.
// RL13: status reset value supports cache enable bits 0x0020 and 0x0080.
// RL14: status reset value supports bits 0x0200, 0x0100 and 0x0008.
// RL15: status reset value supports interrupt enable 0x0002, live from reset.
// RL16: vectors sit at a base address, default zero, seven low bits zero.
// RL17: version option 0 none, 1 first register, 2 both registers.
// RL18: first version register bits 31 to 24 hold a user byte when present.
// RL19: second version register holds a user word, only when option is full.
// RL20: stop input high halts the core within a few instructions.
// RL21: halted output high for breakpoint, debugger stop or stop input halts.
// RL22: halted output clears when the debugger resumes execution.
// RL23: exceptions need enable set and none in progress; interrupts need enable set.
module sxh_exc_unit #(
	parameter        fpu_exc_en        = 1,
	parameter        div_exc_en        = 1,
	parameter        ibus_exc_en       = 1,
	parameter        dbus_exc_en       = 1,
	parameter        ill_exc_en        = 1,
	parameter        null_opcode_trap_option = 1,
	parameter        stream_exc_en     = 1,
	parameter        stream_instr_en   = 1,
	parameter        stack_prot_en     = 1,
	parameter        edge_sense_param  = 0,
	parameter        edge_polarity_param = 1,
	parameter [1:0]  irq_use           = `SXH_IRQ_NORMAL,
	parameter [31:0] mstat_reset       = `SXH_MS_RESET,
	parameter [31:0] vec_base          = `SXH_VEC_BASE,
	parameter [1:0]  version_reg_option = `SXH_VER_NONE,
	parameter [7:0]  custom_field_a    = `SXH_USER_A,    // arbitrary
	parameter [31:0] custom_word_b     = `SXH_USER_B     // arbitrary
) (
	// clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// ahb-lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	// core event reports, one-cycle pulses
	input  wire [4:0]  fpu_flags,
	input  wire        div_zero,
	input  wire        div_ovf,
	input  wire        div_signed,
	input  wire        ibus_err,
	input  wire        dbus_err,
	input  wire        decode_valid,
	input  wire [31:0] decode_word,
	input  wire        opcode_bad,
	input  wire        stream_rd_err,
	input  wire        sp_access,
	input  wire [31:0] sp_addr,
	input  wire        exc_return,
	input  wire        irq_return,
	input  wire        brk_hit,
	input  wire        instr_retire,
	// interrupt and debug
	input  wire        irq_in,
	input  wire        dbg_stop,
	input  wire        dbg_halt_cmd,
	input  wire        dbg_resume,
	// core controls
	output reg         exc_take,
	output reg  [3:0]  exc_cause,
	output reg         irq_take,
	output reg         null_as_nop,
	output reg  [31:0] vec_reset,
	output reg  [31:0] vec_user,
	output reg  [31:0] vec_irq,
	output reg  [31:0] vec_brk,
	output reg  [31:0] vec_hwexc,
	output reg         instr_cache_on,
	output reg         data_cache_on,
	output reg         core_halted_out
);
	localparam [2:0] st_run  = 3'h1;
	localparam [2:0] st_stop = 3'h2;
	localparam [2:0] st_halt = 3'h4;

	reg  [31:0] machine_status_reg_r;
	reg  [31:0] stack_low_limit_r;
	reg  [31:0] stack_high_limit_r;
	reg  [3:0]  cause_r;
	reg  [2:0]  dbg_st_r;
	reg  [1:0]  stop_cnt_r;
	reg         wr_pend_r;
	reg         rd_pend_r;
	reg  [11:0] addr_r;
	reg  [3:0]  cause_nxt;
	reg  [31:0] mstat_nxt;
	reg  [31:0] processor_version_reg;
	wire        irq_pending;
	wire        stack_bad;
	wire        exc_ok;
	wire        null_word;
	wire [31:0] base_ok;

	// ------------------------------------------------------------
	// interrupt sense
	// ------------------------------------------------------------
	sxh_irq_sense #(
		.edge_sense_param   (edge_sense_param),
		.edge_polarity_param(edge_polarity_param),
		.irq_use            (irq_use)
	) u_sense (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.irq_in     (irq_in),
		.irq_ack    (irq_take),
		.irq_pending(irq_pending)
	);

	// ------------------------------------------------------------
	// exception detection
	// ------------------------------------------------------------
	function is_reg;
		input [11:0] a;
		input [11:0] off;
		begin
			is_reg = (a == off);
		end
	endfunction

	assign null_word = decode_valid && (decode_word == 32'h0000_0000);
	assign stack_bad = (stack_prot_en != 0) && sp_access &&
		((sp_addr < stack_low_limit_r) || (sp_addr > stack_high_limit_r)); // see RL8
	assign exc_ok = machine_status_reg_r[`SXH_BIT_EXCEN] &&
		!machine_status_reg_r[`SXH_BIT_EXCIP]; // see RL23

	// fixed priority: bus errors first, then decode, then execute
	always @* begin
		cause_nxt = `SXH_EXC_NONE;
		if (ibus_exc_en != 0 && ibus_err)
			cause_nxt = `SXH_EXC_IBUS; // see RL3
		else if (dbus_exc_en != 0 && dbus_err)
			cause_nxt = `SXH_EXC_DBUS; // see RL4
		else if (ill_exc_en != 0 && decode_valid && opcode_bad)
			cause_nxt = `SXH_EXC_ILLEGAL; // see RL5
		else if (ill_exc_en != 0 && null_opcode_trap_option != 0 && null_word)
			cause_nxt = `SXH_EXC_ILLEGAL; // see RL6
		else if (div_exc_en != 0 && (div_zero || (div_signed && div_ovf)))
			cause_nxt = `SXH_EXC_DIV; // see RL2
		else if (fpu_exc_en != 0 && (|fpu_flags))
			cause_nxt = `SXH_EXC_FPU; // see RL1
		else if (stream_exc_en != 0 && stream_instr_en != 0 && stream_rd_err)
			cause_nxt = `SXH_EXC_STREAM; // see RL7
		else if (stack_bad)
			cause_nxt = `SXH_EXC_STACK; // see RL8
	end

	// ------------------------------------------------------------
	// version register and vectors
	// ------------------------------------------------------------
	// low seven base bits are forced clear rather than trusted
	assign base_ok = vec_base & ~`SXH_VEC_LOWMASK; // see RL16

	always @* begin
		processor_version_reg = 32'h0000_0000;
		if (version_reg_option == `SXH_VER_BASIC || version_reg_option == `SXH_VER_FULL)
			processor_version_reg[31:`SXH_VER_USR_LSB] = custom_field_a; // see RL17 RL18
	end

	// ------------------------------------------------------------
	// ahb-lite slave, zero wait states
	// ------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r    <= 12'h000;
		end else if (hready) begin
			wr_pend_r <= hsel && htrans[1] && hwrite;
			rd_pend_r <= hsel && htrans[1] && !hwrite;
			addr_r    <= haddr[11:0];
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			case (haddr[11:0])
			`SXH_OFF_MSTAT:   hrdata <= machine_status_reg_r;
			`SXH_OFF_VER0:    hrdata <= processor_version_reg;
			`SXH_OFF_VER1:    hrdata <= (version_reg_option == `SXH_VER_FULL) ?
				custom_word_b : 32'h0000_0000; // see RL19
			`SXH_OFF_CAUSE:   hrdata <= {28'h0000000, cause_r};
			`SXH_OFF_DBG:     hrdata <= {29'h00000000, dbg_st_r};
			`SXH_OFF_SLOW:    hrdata <= stack_low_limit_r;
			`SXH_OFF_SHIGH:   hrdata <= stack_high_limit_r;
			`SXH_OFF_VECBASE: hrdata <= base_ok;
			`SXH_OFF_STATUS:  hrdata <= {30'h00000000, irq_pending, core_halted_out};
			default:          hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// machine status register and exception / interrupt take
	// ------------------------------------------------------------
	always @* begin
		mstat_nxt = machine_status_reg_r;
		if (wr_pend_r && is_reg(addr_r, `SXH_OFF_MSTAT))
			mstat_nxt = (machine_status_reg_r & ~`SXH_MS_WMASK) | (hwdata & `SXH_MS_WMASK);
		if (exc_return)
			mstat_nxt = mstat_nxt & ~`SXH_MS_EXCIP;
		if (irq_return)
			mstat_nxt = mstat_nxt | `SXH_MS_INTEN;
		// hardware events win over a software write in the same cycle
		if (brk_hit)
			mstat_nxt = mstat_nxt | `SXH_MS_BRKIP;
		if (cause_nxt != `SXH_EXC_NONE && exc_ok)
			mstat_nxt = (mstat_nxt | `SXH_MS_EXCIP) & ~`SXH_MS_EXCEN; // see RL23
		else if (irq_pending && machine_status_reg_r[`SXH_BIT_INTEN] && dbg_st_r != st_halt)
			mstat_nxt = mstat_nxt & ~`SXH_MS_INTEN; // see RL23
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			machine_status_reg_r <= mstat_reset & `SXH_MS_WMASK; // see RL13 RL14 RL15
			stack_low_limit_r    <= 32'h0000_0000;
			stack_high_limit_r   <= 32'hffff_ffff;
			cause_r              <= `SXH_EXC_NONE;
			exc_take             <= 1'b0;
			exc_cause            <= `SXH_EXC_NONE;
			irq_take             <= 1'b0;
		end else begin
			machine_status_reg_r <= mstat_nxt;
			if (wr_pend_r && is_reg(addr_r, `SXH_OFF_SLOW))
				stack_low_limit_r <= hwdata;
			if (wr_pend_r && is_reg(addr_r, `SXH_OFF_SHIGH))
				stack_high_limit_r <= hwdata;
			exc_take  <= (cause_nxt != `SXH_EXC_NONE) && exc_ok; // see RL23
			exc_cause <= exc_ok ? cause_nxt : `SXH_EXC_NONE;
			if (cause_nxt != `SXH_EXC_NONE && exc_ok)
				cause_r <= cause_nxt;
			// interrupt waits behind an exception and during a halt
			irq_take <= irq_pending && machine_status_reg_r[`SXH_BIT_INTEN] &&
				!((cause_nxt != `SXH_EXC_NONE) && exc_ok) &&
				(dbg_st_r != st_halt) && !irq_take; // see RL12 RL23
		end
	end

	// ------------------------------------------------------------
	// vector, null no-op and cache enable outputs
	// ------------------------------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vec_reset      <= 32'h0000_0000;
			vec_user       <= 32'h0000_0000;
			vec_irq        <= 32'h0000_0000;
			vec_brk        <= 32'h0000_0000;
			vec_hwexc      <= 32'h0000_0000;
			null_as_nop    <= 1'b0;
			instr_cache_on <= 1'b0;
			data_cache_on  <= 1'b0;
		end else begin
			vec_reset      <= base_ok + `SXH_VOFF_RESET; // see RL16
			vec_user       <= base_ok + `SXH_VOFF_USER;
			vec_irq        <= base_ok + `SXH_VOFF_IRQ;
			vec_brk        <= base_ok + `SXH_VOFF_BRK;
			vec_hwexc      <= base_ok + `SXH_VOFF_HWEXC;
			// zero word runs as no-op unless the trap applies
			null_as_nop    <= null_word &&
				!(ill_exc_en != 0 && null_opcode_trap_option != 0); // see RL6
			instr_cache_on <= (mstat_nxt & `SXH_MS_ICON) != 32'h0000_0000; // see RL13
			data_cache_on  <= (mstat_nxt & `SXH_MS_DCON) != 32'h0000_0000; // see RL13
		end
	end

	// ------------------------------------------------------------
	// debug halt
	// ------------------------------------------------------------
	// stop input lets a couple of instructions drain before halting
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dbg_st_r        <= st_run;
			stop_cnt_r      <= 2'h0;
			core_halted_out <= 1'b0;
		end else begin
			case (dbg_st_r)
			st_run: begin
				if (brk_hit || dbg_halt_cmd) begin
					dbg_st_r        <= st_halt;
					core_halted_out <= 1'b1; // see RL21
				end else if (dbg_stop) begin
					dbg_st_r   <= st_stop; // see RL20
					stop_cnt_r <= `SXH_STOP_DELAY;
				end
			end
			st_stop: begin
				if (brk_hit || dbg_halt_cmd || stop_cnt_r == 2'h0) begin
					dbg_st_r        <= st_halt;
					core_halted_out <= 1'b1; // see RL20 RL21
				end else if (instr_retire) begin
					stop_cnt_r <= stop_cnt_r - 2'h1;
				end
			end
			st_halt: begin
				if (dbg_resume) begin
					dbg_st_r        <= st_run;
					core_halted_out <= 1'b0; // see RL22
				end
			end
			default: begin
				dbg_st_r        <= st_run;
				core_halted_out <= 1'b0;
			end
			endcase
		end
	end

endmodule
`default_nettype wire

// ### sxh_far_model.sv
// sxh_far_model.sv: interrupt source and debug stop driver facing the exception unit
// assumes the bench raises irq_req, stop_req and run just after rising edges of hclk
`timescale 1ns/1ps
`default_nettype none
module sxh_far_model (
	// clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// bench requests
	input  wire logic irq_req,
	input  wire logic stop_req,
	input  wire logic run,
	// core status
	input  wire logic core_halted_out,
	// lines toward the core
	output var  logic irq_in,
	output var  logic dbg_stop,
	output var  logic instr_retire
);
	logic [1:0] tick_r;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_in       <= 1'b0;
			dbg_stop     <= 1'b0;
			instr_retire <= 1'b0;
			tick_r       <= 2'h0;
		end else begin
			// level source follows irq_req one cycle late and holds it until the bench drops irq_req
			irq_in <= irq_req;
			if (core_halted_out)
				dbg_stop <= 1'b0;
			else if (stop_req)
				dbg_stop <= 1'b1;
			// slow core: one retire every fourth cycle
			tick_r       <= tick_r + 2'h1;
			instr_retire <= run && tick_r == 2'h3;
		end
	end
endmodule
`default_nettype wire

// ### sxh_exc_props.sv
// sxh_exc_props.sv: port-level assertions for the exception unit
// assumes a single hclk domain with hresetn active low
`timescale 1ns/1ps
`default_nettype none
module sxh_exc_props #(
	parameter edge_sense_param = 0
) (
	// clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// events and takes
	input wire logic        ibus_err,
	input wire logic        dbus_err,
	input wire logic        irq_in,
	input wire logic        exc_take,
	input wire logic [3:0]  exc_cause,
	input wire logic        irq_take,
	// debug
	input wire logic        dbg_halt_cmd,
	input wire logic        dbg_resume,
	input wire logic        brk_hit,
	input wire logic        dbg_stop,
	input wire logic        core_halted_out,
	// vectors
	input wire logic [31:0] vec_reset,
	input wire logic [31:0] vec_irq,
	input wire logic [31:0] vec_hwexc
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	ibus_cause_a: assert property (exc_take && exc_cause == 4'h3 |-> $past(ibus_err))
		else $error("ibus cause without bus error");
	dbus_cause_a: assert property (exc_take && exc_cause == 4'h4
		|-> $past(dbus_err && !ibus_err))
		else $error("dbus cause without bus error");
	exc_single_a: assert property (exc_take |=> !exc_take)
		else $error("exception taken while one in progress");
	irq_level_a: assert property (irq_take |-> edge_sense_param != 0 || $past(irq_in))
		else $error("interrupt taken with input low");
	irq_gap_a: assert property (irq_take |=> !irq_take)
		else $error("interrupt taken with enable cleared");
	halt_cmd_a: assert property (dbg_halt_cmd && !dbg_resume |=> core_halted_out)
		else $error("halt command did not halt");
	brk_halt_a: assert property (brk_hit && !dbg_resume |=> core_halted_out)
		else $error("breakpoint did not halt");
	resume_clear_a: assert property (core_halted_out && dbg_resume
		&& !dbg_halt_cmd && !brk_hit |=> !core_halted_out)
		else $error("resume did not clear halted");
	halt_cause_a: assert property ($rose(core_halted_out)
		|-> $past(dbg_halt_cmd || brk_hit || dbg_stop))
		else $error("halted without a cause");
	vec_step_a: assert property ($past(hresetn) |-> vec_irq == vec_reset + 32'h10
		&& vec_hwexc == vec_reset + 32'h20 && vec_reset[6:0] == 7'h00)
		else $error("vector layout wrong");

	exc_c: cover property (exc_take);
	irq_c: cover property (irq_take);
	stop_c: cover property ($rose(core_halted_out) && dbg_stop);
endmodule

bind sxh_exc_unit sxh_exc_props #(.edge_sense_param(edge_sense_param)) u_props (
	.hclk(hclk), .hresetn(hresetn), .ibus_err(ibus_err), .dbus_err(dbus_err),
	.irq_in(irq_in), .exc_take(exc_take), .exc_cause(exc_cause), .irq_take(irq_take),
	.dbg_halt_cmd(dbg_halt_cmd), .dbg_resume(dbg_resume), .brk_hit(brk_hit),
	.dbg_stop(dbg_stop), .core_halted_out(core_halted_out), .vec_reset(vec_reset),
	.vec_irq(vec_irq), .vec_hwexc(vec_hwexc));
`default_nettype wire

// ### sxh_exc_unit_test.sv
// sxh_exc_unit_test.sv: self-checking bench for the exception unit
// assumes sxh_far_model drives the interrupt, stop and retire lines
`timescale 1ns/1ps
`default_nettype none
module sxh_exc_unit_test;
	logic        hclk, hresetn, hsel, hwrite, irq_req, stop_req, run;
	logic [31:0] haddr, hwdata, hrdata, sp_addr, word_r, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  exc_cause;
	logic [17:0] ev;
	logic [15:0] seed;
	logic [31:0] vec_reset, vec_user, vec_irq, vec_brk, vec_hwexc;
	logic        hreadyout, hresp, exc_take, irq_take, irq_in, dbg_stop, instr_retire;
	logic        instr_cache_on, data_cache_on, core_halted_out, null_as_nop;
	wire logic   hready;
	logic [3:0]  cause [13];
	logic [11:0] ta [8];
	logic [31:0] te [8];
	integer      failures, samples_checked, i, n;

	assign hready = hreadyout;

	sxh_exc_unit #(.mstat_reset(32'h0000_01a2), .vec_base(32'h0000_1045),
		.version_reg_option(2'h2), .custom_field_a(8'h5c), // arbitrary
		.custom_word_b(32'h1357_9bdf)) uut ( // arbitrary
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.fpu_flags(ev[10:6]), .div_zero(ev[4]), .div_ovf(ev[5]), .div_signed(ev[5]),
		.ibus_err(ev[0]), .dbus_err(ev[1]), .decode_valid(ev[2] | ev[3]),
		.decode_word(ev[3] ? 32'h0 : word_r), .opcode_bad(ev[2]), .stream_rd_err(ev[11]),
		.sp_access(ev[12]), .sp_addr(sp_addr), .exc_return(ev[16]), .irq_return(ev[17]),
		.brk_hit(ev[14]), .instr_retire(instr_retire), .irq_in(irq_in), .dbg_stop(dbg_stop),
		.dbg_halt_cmd(ev[13]), .dbg_resume(ev[15]), .exc_take(exc_take),
		.exc_cause(exc_cause), .irq_take(irq_take), .null_as_nop(null_as_nop),
		.vec_reset(vec_reset),
		.vec_user(vec_user), .vec_irq(vec_irq), .vec_brk(vec_brk), .vec_hwexc(vec_hwexc),
		.instr_cache_on(instr_cache_on), .data_cache_on(data_cache_on),
		.core_halted_out(core_halted_out));

	sxh_far_model far (.hclk(hclk), .hresetn(hresetn), .irq_req(irq_req),
		.stop_req(stop_req), .run(run), .core_halted_out(core_halted_out),
		.irq_in(irq_in), .dbg_stop(dbg_stop), .instr_retire(instr_retire));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked = samples_checked + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task results;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// bounded wait for hready at a rising edge
	task wait_rdy;
		n = 0;
		@(posedge hclk);
		while (hready !== 1'b1 && n < 16) begin
			n = n + 1;
			@(posedge hclk);
		end
		if (n >= 16) begin
			failures = failures + 1;
			results;
		end
	endtask

	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {20'h0, a};
		hsize  <= 3'h2;
		wait_rdy;
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		rd = hrdata;
	endtask

	task pulse(input integer k);
		ev <= 18'h1 << k;
		@(posedge hclk);
		ev <= 18'h0;
		#1;
	endtask

	// one event; on a take, clear progress and re-enable exceptions
	task fire(input integer k, input logic [3:0] c, input logic take);
		seed = lfsr(seed);
		word_r <= {seed, ~seed};
		pulse(k);
		chk({31'h0, exc_take}, {31'h0, take});
		chk({31'h0, null_as_nop}, 32'h0);
		if (take) begin
			chk({28'h0, exc_cause}, {28'h0, c});
			bus(1'b0, 12'h000, 32'h0);
			chk(rd, (32'h1a2 | 32'h200) & ~32'h100);
			pulse(16);
			bus(1'b1, 12'h000, 32'h1a2);
		end
	endtask

	task wait_irq(input logic exp);
		for (n = 0; n < 8 && irq_take !== 1'b1; n = n + 1) begin
			@(posedge hclk);
			#1;
		end
		chk({31'h0, irq_take}, {31'h0, exp});
	endtask

	// ------------------------------------------------------------
	// clock, watchdog, sequence
	// ------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	initial begin
		repeat (20000) @(posedge hclk);
		failures = failures + 1;
		results;
	end

	initial begin
		{hresetn, hsel, hwrite, irq_req, stop_req, run} = 6'h0;
		{haddr, hwdata, sp_addr, word_r} = 128'h0;
		{htrans, hsize, ev} = 23'h0;
		seed = 16'h63a6;
		failures = 0;
		samples_checked = 0;
		cause = '{4'h3, 4'h4, 4'h2, 4'h2, 4'h5, 4'h5, 4'h6, 4'h6, 4'h6, 4'h6, 4'h6, 4'h1, 4'h7};
		ta = '{12'h000, 12'h008, 12'h00c, 12'h010, 12'h018, 12'h01c, 12'h020, 12'h100};
		te = '{32'h1a2, 32'h1357_9bdf, 32'h0, 32'h1, 32'hffff_ffff, 32'h1000, 32'h0, 32'h0};
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		#1;
		chk({30'h0, instr_cache_on, data_cache_on}, 32'h3);
		chk(vec_user, 32'h1008);
		chk(vec_brk, 32'h1018);
		// read-only and unmapped writes must not land
		bus(1'b1, 12'h008, 32'h0);
		bus(1'b1, 12'h100, 32'hffff_ffff);
		for (i = 0; i < 8; i = i + 1) begin
			bus(1'b0, ta[i], 32'h0);
			chk(rd, te[i]);
		end
		bus(1'b0, 12'h004, 32'h0);
		chk({24'h0, rd[31:24]}, 32'h5c);
		// level interrupt, live from reset
		irq_req <= 1'b1;
		wait_irq(1'b1);
		bus(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h1a0);
		pulse(17);
		wait_irq(1'b1);
		irq_req <= 1'b0;
		repeat (2) @(posedge hclk);
		pulse(17);
		wait_irq(1'b0);
		bus(1'b1, 12'h000, 32'h1a0);
		irq_req <= 1'b1;
		wait_irq(1'b0);
		bus(1'b0, 12'h020, 32'h0);
		chk(rd, 32'h2);
		irq_req <= 1'b0;
		repeat (2) @(posedge hclk);
		bus(1'b1, 12'h000, 32'h1a2);
		// exceptions of every kind, then refusals
		bus(1'b1, 12'h014, 32'h1000);
		bus(1'b1, 12'h018, 32'h1fff);
		sp_addr <= 32'h2000;
		for (i = 0; i < 13; i = i + 1)
			fire(i, cause[i], 1'b1);
		sp_addr <= 32'h1ff0;
		fire(12, 4'h7, 1'b0);
		bus(1'b1, 12'h000, 32'h0a2);
		fire(0, 4'h3, 1'b0);
		bus(1'b1, 12'h000, 32'h1a2);
		// halt by command, by breakpoint, by stop input
		pulse(13);
		chk({31'h0, core_halted_out}, 32'h1);
		bus(1'b0, 12'h010, 32'h0);
		chk(rd, 32'h4);
		pulse(15);
		chk({31'h0, core_halted_out}, 32'h0);
		pulse(14);
		chk({31'h0, core_halted_out}, 32'h1);
		bus(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h1aa);
		pulse(15);
		bus(1'b1, 12'h000, 32'h1a2);
		stop_req <= 1'b1;
		for (n = 0; n < 8 && dbg_stop !== 1'b1; n = n + 1) begin
			@(posedge hclk);
			#1;
		end
		chk({31'h0, dbg_stop}, 32'h1);
		stop_req <= 1'b0;
		run <= 1'b1;
		i = 0;
		for (n = 0; n < 40 && core_halted_out !== 1'b1; n = n + 1) begin
			@(posedge hclk);
			#1;
			if (instr_retire === 1'b1)
				i = i + 1;
		end
		chk(i, 32'h2);
		bus(1'b0, 12'h020, 32'h0);
		chk(rd, 32'h1);
		run <= 1'b0;
		pulse(15);
		chk({31'h0, core_halted_out}, 32'h0);
		results;
	end
endmodule
`default_nettype wire
